// ---- include/vfp_pkg.sv ----
package vfp_pkg;
  // register byte offsets on the apb port
  localparam logic [7:0] VFP_OFS_FC3 = 8'h00;
  localparam logic [7:0] VFP_OFS_FC3_MASK = 8'h04;
  localparam logic [7:0] VFP_OFS_CTRL = 8'h08;
  localparam logic [7:0] VFP_OFS_THR = 8'h0C;
  localparam logic [7:0] VFP_OFS_ENABLE = 8'h10;
  localparam logic [7:0] VFP_OFS_STATUS = 8'h14;
  localparam logic [7:0] VFP_OFS_FIELDS = 8'h18;
  // framing_and_compensation_ctrl layout
  localparam int unsigned VFP_FC1_LSB = 8;
  localparam int unsigned VFP_AGD_BIT = 7;
  localparam int unsigned VFP_AFR_BIT = 6;
  localparam int unsigned VFP_ANO_BIT = 5;
  localparam int unsigned VFP_PRE_LSB = 1;
  localparam int unsigned VFP_FULL_BIT = 0;
  // start_level_and_delay_thresholds layout
  localparam int unsigned VFP_STL_LSB = 8;
  localparam int unsigned VFP_MUX_BIT = 6;
  localparam int unsigned VFP_NEG_LSB = 3;
  localparam int unsigned VFP_POS_LSB = 0;
  // enable register layout
  localparam int unsigned VFP_EXT_STL_BIT = 0;
  localparam int unsigned VFP_THR_EN_BIT = 1;
  // reset values, chosen defined although the memory words start unknown
  localparam logic [15:0] VFP_RST_WORD = 16'h0000;
  localparam logic [6:0] VFP_INT_STL_DEF = 7'h20;
  localparam logic [2:0] VFP_THR_OFF = 3'h0;
  localparam logic [31:0] VFP_RD_ZERO = 32'h00000000;

  // one complete set of field parameters
  typedef struct packed {
    logic [15:0] fc3;
    logic [15:0] fc3_mask;
    logic [7:0] fc1;
    logic agd;
    logic afr;
    logic ano;
    logic [3:0] wss_pre;
    logic full;
    logic [6:0] s2_stl;
    logic delay_measure_input_select;
    logic [2:0] gd_neg;
    logic [2:0] gd_pos;
  } vfp_params_t;

  // field fetch sequencer
  typedef enum logic [2:0] {
    VFP_ARMED = 3'b001,
    VFP_LOAD = 3'b010,
    VFP_HOLD = 3'b100
  } vfp_state_t;
endpackage

// ---- core/vfp_match.sv ----
`timescale 1ns/1ps
module vfp_match
  import vfp_pkg::*;
#(
  parameter int unsigned CODE_W = 16
) (
  input wire logic clk,
  input wire logic rst,
  input wire logic rx_bit,
  input wire logic rx_valid,
  input wire logic [CODE_W-1:0] code_three,
  input wire logic [CODE_W-1:0] code_mask,
  input wire logic [7:0] code_one,
  input wire logic [3:0] precision,
  input wire logic [3:0] edge_hits,
  output logic fc3_hit,
  output logic fc1_hit,
  output logic wss_hit
);
  // received bits, oldest in the top bit
  logic [CODE_W-1:0] shift;

  // shift in at the bottom so bit 15 holds the first received bit
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      shift <= '0;
    end else if (rx_valid) begin
      shift <= {shift[CODE_W-2:0], rx_bit};
    end
  end

  // masked compare of code three, plain compare of code one
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      fc3_hit <= 1'b0;
      fc1_hit <= 1'b0;
    end else begin
      fc3_hit <= ((shift ^ code_three) & code_mask) == '0;
      fc1_hit <= shift[7:0] == code_one;
    end
  end

  // wide-screen code accepted when enough edge samples are exact
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      wss_hit <= 1'b0;
    end else begin
      wss_hit <= edge_hits >= precision;
    end
  end

  fc3_mask_a: assert property (@(posedge clk) disable iff (rst)
    !$past(rst) |=> fc3_hit == ((($past(shift) ^ $past(code_three)) & $past(code_mask)) == '0))
    else $error("masked code three compare wrong");
  wss_prec_a: assert property (@(posedge clk) disable iff (rst)
    (!$past(rst) && precision == 4'h0) |=> wss_hit)
    else $error("zero precision must always accept");
endmodule // vfp_match

// ---- core/vfp_top.sv ----
// Notes on behaviour
// - whole parameter set refreshed once per field; the two enable register bits reach the outputs one cycle after their write
// - status captured as one snapshot per field
// - either input's valid sync keeps updates going
// - code three bit 15 is first bit
// - mask bit covers same-position code three bit
// - code one bit 7 is first bit
// - group delay auto compensation follows its flag
// - attenuation auto compensation follows its flag
// - noise auto compensation follows its flag
// - full channel bit switches full channel mode
// - slicer two start level is comparator threshold
// - start level used only when external enabled
// - select chooses raw or compensated measured video
// - negative threshold code zero detects small delay
// - positive threshold code zero detects small delay
// - external enable picks internal or programmed thresholds
// - delay thresholds ignored unless their enable set
//
// The implementer's own choices: the APB slave port and the register addresses.
`timescale 1ns/1ps
module vfp_top
  import vfp_pkg::*;
#(
  parameter logic [6:0] INT_START_LEVEL = VFP_INT_STL_DEF
) (
  input wire logic MCLK,
  input wire logic RST,
  input wire logic PSEL,
  input wire logic PENABLE,
  input wire logic PWRITE,
  input wire logic [7:0] PADDR,
  input wire logic [31:0] PWDATA,
  output logic [31:0] PRDATA,
  output logic PREADY,
  output logic PSLVERR,
  input wire logic VSYNC_ONE,
  input wire logic VSYNC_TWO,
  input wire logic SYNC_OK_ONE,
  input wire logic SYNC_OK_TWO,
  input wire logic [15:0] SLICER_STATUS,
  input wire logic RX_BIT,
  input wire logic RX_BIT_VALID,
  input wire logic [3:0] WSS_EDGE_HITS,
  output logic FIELD_STROBE,
  output logic FC3_HIT,
  output logic FC1_HIT,
  output logic WSS_FC_HIT,
  output logic GROUP_DELAY_COMP_ON,
  output logic ATTEN_COMP_ON,
  output logic NOISE_COMP_ON,
  output logic FULL_CHANNEL_ON,
  output logic USE_EXT_START_LEVEL,
  output logic [6:0] SLICER_TWO_START_LEVEL,
  output logic DELAY_MEASURE_SELECT,
  output logic DELAY_THR_VALID,
  output logic [2:0] NEG_DELAY_THRESHOLD,
  output logic [2:0] POS_DELAY_THRESHOLD
);
  // pass a threshold code only while its enable is set
  function automatic logic [2:0] gate_thr(input logic en, input logic [2:0] code);
    gate_thr = en ? code : VFP_THR_OFF;
  endfunction

  vfp_params_t prog; // software image, written at any time
  vfp_params_t act; // set in force for the current field
  logic ext_stl_en; // external start level enable
  logic thr_en; // delay threshold enable
  logic [15:0] status_snap; // per-field slicer status
  logic [15:0] field_count; // fields fetched since reset
  vfp_state_t state; // fetch sequencer state
  vfp_state_t next_state;
  logic [1:0] vs1_sync, vs2_sync, ok1_sync, ok2_sync; // pin synchronisers
  logic vs_sel_d; // selected vsync, one cycle late
  logic vs_sel; // vsync of the input that has valid timing
  logic field_edge; // start of a field
  logic setup_ph; // apb setup cycle
  logic wr_take; // apb write taking effect
  logic [31:0] rd_word; // read data decode

  // two flops on each vsync and sync ok pin; only the second stage is read below
  always_ff @(posedge MCLK or posedge RST) begin
    if (RST) begin
      vs1_sync <= 2'b00;
      vs2_sync <= 2'b00;
      ok1_sync <= 2'b00;
      ok2_sync <= 2'b00;
    end else begin
      vs1_sync <= {vs1_sync[0], VSYNC_ONE};
      vs2_sync <= {vs2_sync[0], VSYNC_TWO};
      ok1_sync <= {ok1_sync[0], SYNC_OK_ONE};
      ok2_sync <= {ok2_sync[0], SYNC_OK_TWO};
    end
  end

  // input one leads; input two takes over when one has no valid sync
  always_comb begin
    if (ok1_sync[1]) begin
      vs_sel = vs1_sync[1];
    end else if (ok2_sync[1]) begin
      vs_sel = vs2_sync[1];
    end else begin
      vs_sel = 1'b0;
    end
    field_edge = vs_sel & ~vs_sel_d;
  end

  // edge detector on the selected vsync
  always_ff @(posedge MCLK or posedge RST) begin
    if (RST) begin
      vs_sel_d <= 1'b0;
    end else begin
      vs_sel_d <= vs_sel;
    end
  end

  // sequencer: arm, load once, hold until vsync drops
  always_comb begin
    case (state)
      VFP_ARMED: next_state = field_edge ? VFP_LOAD : VFP_ARMED;
      VFP_LOAD: next_state = VFP_HOLD;
      VFP_HOLD: next_state = vs_sel ? VFP_HOLD : VFP_ARMED;
      default: next_state = VFP_ARMED;
    endcase
  end

  // state register
  always_ff @(posedge MCLK or posedge RST) begin
    if (RST) begin
      state <= VFP_ARMED;
    end else begin
      state <= next_state;
    end
  end

  // take the whole set up at the load step only
  always_ff @(posedge MCLK or posedge RST) begin
    if (RST) begin
      act <= '0;
    end else if (state == VFP_LOAD) begin
      act <= prog;
    end
  end

  // status snapshot and field counter, both at the load step
  always_ff @(posedge MCLK or posedge RST) begin
    if (RST) begin
      status_snap <= VFP_RST_WORD;
      field_count <= VFP_RST_WORD;
    end else if (state == VFP_LOAD) begin
      status_snap <= SLICER_STATUS;
      field_count <= field_count + 16'h0001;
    end
  end

  // apb phase decode
  assign setup_ph = PSEL & ~PENABLE;
  assign wr_take = PSEL & PENABLE & PREADY & PWRITE;

  // software writes into the image, never into the active set
  always_ff @(posedge MCLK or posedge RST) begin
    if (RST) begin
      prog <= '0;
      ext_stl_en <= 1'b0;
      thr_en <= 1'b0;
    end else if (wr_take) begin
      case (PADDR)
        VFP_OFS_FC3: prog.fc3 <= PWDATA[15:0];
        VFP_OFS_FC3_MASK: prog.fc3_mask <= PWDATA[15:0];
        VFP_OFS_CTRL: begin
          prog.fc1 <= PWDATA[VFP_FC1_LSB +: 8];
          prog.agd <= PWDATA[VFP_AGD_BIT];
          prog.afr <= PWDATA[VFP_AFR_BIT];
          prog.ano <= PWDATA[VFP_ANO_BIT];
          prog.wss_pre <= PWDATA[VFP_PRE_LSB +: 4];
          prog.full <= PWDATA[VFP_FULL_BIT];
        end
        VFP_OFS_THR: begin
          prog.s2_stl <= PWDATA[VFP_STL_LSB +: 7];
          prog.delay_measure_input_select <= PWDATA[VFP_MUX_BIT];
          prog.gd_neg <= PWDATA[VFP_NEG_LSB +: 3];
          prog.gd_pos <= PWDATA[VFP_POS_LSB +: 3];
        end
        VFP_OFS_ENABLE: begin
          ext_stl_en <= PWDATA[VFP_EXT_STL_BIT];
          thr_en <= PWDATA[VFP_THR_EN_BIT];
        end
        default: begin
        end
      endcase
    end
  end

  // read decode; reserved bits read zero
  always_comb begin
    rd_word = VFP_RD_ZERO;
    case (PADDR)
      VFP_OFS_FC3: rd_word[15:0] = prog.fc3;
      VFP_OFS_FC3_MASK: rd_word[15:0] = prog.fc3_mask;
      VFP_OFS_CTRL: begin
        rd_word[VFP_FC1_LSB +: 8] = prog.fc1;
        rd_word[VFP_AGD_BIT] = prog.agd;
        rd_word[VFP_AFR_BIT] = prog.afr;
        rd_word[VFP_ANO_BIT] = prog.ano;
        rd_word[VFP_PRE_LSB +: 4] = prog.wss_pre;
        rd_word[VFP_FULL_BIT] = prog.full;
      end
      VFP_OFS_THR: begin
        rd_word[VFP_STL_LSB +: 7] = prog.s2_stl;
        rd_word[VFP_MUX_BIT] = prog.delay_measure_input_select;
        rd_word[VFP_NEG_LSB +: 3] = prog.gd_neg;
        rd_word[VFP_POS_LSB +: 3] = prog.gd_pos;
      end
      VFP_OFS_ENABLE: begin
        rd_word[VFP_EXT_STL_BIT] = ext_stl_en;
        rd_word[VFP_THR_EN_BIT] = thr_en;
      end
      VFP_OFS_STATUS: rd_word[15:0] = status_snap;
      VFP_OFS_FIELDS: rd_word[15:0] = field_count;
      default: rd_word = VFP_RD_ZERO;
    endcase
  end

  // zero-wait slave: ready rises with the first access cycle
  always_ff @(posedge MCLK or posedge RST) begin
    if (RST) begin
      PREADY <= 1'b0;
      PRDATA <= VFP_RD_ZERO;
      PSLVERR <= 1'b0;
    end else if (setup_ph) begin
      PREADY <= 1'b1;
      PRDATA <= PWRITE ? VFP_RD_ZERO : rd_word;
      PSLVERR <= (PADDR > VFP_OFS_FIELDS) || (PADDR[1:0] != 2'b00);
    end else begin
      PREADY <= 1'b0;
      PSLVERR <= 1'b0;
    end
  end

  // control outputs from the active set, one flop each
  always_ff @(posedge MCLK or posedge RST) begin
    if (RST) begin
      GROUP_DELAY_COMP_ON <= 1'b0;
      ATTEN_COMP_ON <= 1'b0;
      NOISE_COMP_ON <= 1'b0;
      FULL_CHANNEL_ON <= 1'b0;
      DELAY_MEASURE_SELECT <= 1'b0;
    end else begin
      GROUP_DELAY_COMP_ON <= act.agd;
      ATTEN_COMP_ON <= act.afr;
      NOISE_COMP_ON <= act.ano;
      FULL_CHANNEL_ON <= act.full;
      DELAY_MEASURE_SELECT <= act.delay_measure_input_select;
    end
  end

  // start level: programmed value or the internal default
  always_ff @(posedge MCLK or posedge RST) begin
    if (RST) begin
      USE_EXT_START_LEVEL <= 1'b0;
      SLICER_TWO_START_LEVEL <= INT_START_LEVEL;
    end else begin
      USE_EXT_START_LEVEL <= ext_stl_en;
      SLICER_TWO_START_LEVEL <= ext_stl_en ? act.s2_stl : INT_START_LEVEL;
    end
  end

  // delay thresholds pass through only while enabled; code zero is most sensitive
  always_ff @(posedge MCLK or posedge RST) begin
    if (RST) begin
      DELAY_THR_VALID <= 1'b0;
      NEG_DELAY_THRESHOLD <= VFP_THR_OFF;
      POS_DELAY_THRESHOLD <= VFP_THR_OFF;
    end else begin
      DELAY_THR_VALID <= thr_en;
      NEG_DELAY_THRESHOLD <= gate_thr(thr_en, act.gd_neg);
      POS_DELAY_THRESHOLD <= gate_thr(thr_en, act.gd_pos);
    end
  end

  // field strobe marks the fetch
  always_ff @(posedge MCLK or posedge RST) begin
    if (RST) begin
      FIELD_STROBE <= 1'b0;
    end else begin
      FIELD_STROBE <= state == VFP_LOAD;
    end
  end

  // framing code checks on the active codes
  vfp_match #(
    .CODE_W(16)
  ) u_match (
    .clk(MCLK),
    .rst(RST),
    .rx_bit(RX_BIT),
    .rx_valid(RX_BIT_VALID),
    .code_three(act.fc3),
    .code_mask(act.fc3_mask),
    .code_one(act.fc1),
    .precision(act.wss_pre),
    .edge_hits(WSS_EDGE_HITS),
    .fc3_hit(FC3_HIT),
    .fc1_hit(FC1_HIT),
    .wss_hit(WSS_FC_HIT)
  );

  // a field edge while armed, then one load, then hold
  sequence field_start_s;
    (state == VFP_ARMED) && field_edge;
  endsequence
  sequence load_hold_s;
    (state == VFP_LOAD) ##1 (state == VFP_HOLD) && FIELD_STROBE;
  endsequence

  field_load_a: assert property (@(posedge MCLK) disable iff (RST)
    field_start_s |=> load_hold_s)
    else $error("field edge did not load once");
  once_field_a: assert property (@(posedge MCLK) disable iff (RST)
    FIELD_STROBE |=> !FIELD_STROBE ##1 !FIELD_STROBE)
    else $error("parameters loaded twice in a field");
  act_hold_a: assert property (@(posedge MCLK) disable iff (RST)
    (state != VFP_LOAD) |=> $stable(act))
    else $error("active set changed outside load");
  snap_hold_a: assert property (@(posedge MCLK) disable iff (RST)
    (state != VFP_LOAD) |=> $stable(status_snap))
    else $error("status snapshot changed inside field");
  snap_take_a: assert property (@(posedge MCLK) disable iff (RST)
    (state == VFP_LOAD) |=> status_snap == $past(SLICER_STATUS))
    else $error("status snapshot not taken");
  second_input_a: assert property (@(posedge MCLK) disable iff (RST)
    (state == VFP_ARMED && !ok1_sync[1] && ok2_sync[1] && vs2_sync[1] && !vs_sel_d)
    |=> state == VFP_LOAD)
    else $error("input two did not start a field");
  start_level_a: assert property (@(posedge MCLK) disable iff (RST)
    !ext_stl_en ##1 !ext_stl_en |-> SLICER_TWO_START_LEVEL == INT_START_LEVEL)
    else $error("start level used while disabled");
  thr_gate_a: assert property (@(posedge MCLK) disable iff (RST)
    !thr_en |=> !DELAY_THR_VALID && NEG_DELAY_THRESHOLD == VFP_THR_OFF
    && POS_DELAY_THRESHOLD == VFP_THR_OFF)
    else $error("thresholds passed while disabled");
  comp_flags_a: assert property (@(posedge MCLK) disable iff (RST)
    FIELD_STROBE |=> GROUP_DELAY_COMP_ON == $past(act.agd) && NOISE_COMP_ON == $past(act.ano)
    && ATTEN_COMP_ON == $past(act.afr))
    else $error("compensation flags do not follow field set");
  apb_ready_a: assert property (@(posedge MCLK) disable iff (RST)
    setup_ph |=> PREADY ##1 !PREADY)
    else $error("apb ready not one cycle after setup");
endmodule // vfp_top

// ---- dv/vbi_slicer_field_params_tb_top.sv ----
`timescale 1ns/1ps
module vbi_slicer_field_params_tb_top
  import vfp_pkg::*;
;
  logic MCLK, RST, PSEL, PENABLE, PWRITE; // clock, reset and apb request
  logic [7:0] PADDR; // apb byte address
  logic [31:0] PWDATA, PRDATA; // apb data
  logic PREADY, PSLVERR, VSYNC_ONE, VSYNC_TWO, SYNC_OK_ONE, SYNC_OK_TWO;
  logic [15:0] SLICER_STATUS; // status that the field load snapshots
  logic RX_BIT, RX_BIT_VALID; // received bit stream
  logic [3:0] WSS_EDGE_HITS; // exact edge sample count
  logic FIELD_STROBE, FC3_HIT, FC1_HIT, WSS_FC_HIT, GROUP_DELAY_COMP_ON, ATTEN_COMP_ON;
  logic NOISE_COMP_ON, FULL_CHANNEL_ON, USE_EXT_START_LEVEL, DELAY_MEASURE_SELECT;
  logic DELAY_THR_VALID;
  logic [6:0] SLICER_TWO_START_LEVEL;
  logic [2:0] NEG_DELAY_THRESHOLD, POS_DELAY_THRESHOLD;
  int error_cnt, total_checks; // mismatch and comparison counters
  logic [31:0] seed; // xorshift state
  logic [15:0] fc3, msk, ctrl, thr, st; // image written this field
  logic [15:0] a_fc3, a_msk, a_ctrl, a_thr, a_st; // set expected to be active
  logic [1:0] en; // enable register image
  logic [15:0] fields; // expected field count

  vfp_top dut (
    .MCLK(MCLK), .RST(RST), .PSEL(PSEL), .PENABLE(PENABLE), .PWRITE(PWRITE),
    .PADDR(PADDR), .PWDATA(PWDATA), .PRDATA(PRDATA), .PREADY(PREADY), .PSLVERR(PSLVERR),
    .VSYNC_ONE(VSYNC_ONE), .VSYNC_TWO(VSYNC_TWO), .SYNC_OK_ONE(SYNC_OK_ONE),
    .SYNC_OK_TWO(SYNC_OK_TWO), .SLICER_STATUS(SLICER_STATUS), .RX_BIT(RX_BIT),
    .RX_BIT_VALID(RX_BIT_VALID), .WSS_EDGE_HITS(WSS_EDGE_HITS),
    .FIELD_STROBE(FIELD_STROBE), .FC3_HIT(FC3_HIT), .FC1_HIT(FC1_HIT),
    .WSS_FC_HIT(WSS_FC_HIT), .GROUP_DELAY_COMP_ON(GROUP_DELAY_COMP_ON),
    .ATTEN_COMP_ON(ATTEN_COMP_ON), .NOISE_COMP_ON(NOISE_COMP_ON),
    .FULL_CHANNEL_ON(FULL_CHANNEL_ON), .USE_EXT_START_LEVEL(USE_EXT_START_LEVEL),
    .SLICER_TWO_START_LEVEL(SLICER_TWO_START_LEVEL),
    .DELAY_MEASURE_SELECT(DELAY_MEASURE_SELECT), .DELAY_THR_VALID(DELAY_THR_VALID),
    .NEG_DELAY_THRESHOLD(NEG_DELAY_THRESHOLD), .POS_DELAY_THRESHOLD(POS_DELAY_THRESHOLD)
  );

  // free running clock, 10 ns period
  initial begin
    MCLK = 1'b0;
    forever #5 MCLK = ~MCLK;
  end

  // repeatable pseudo random source
  function automatic logic [31:0] xs();
    seed ^= seed << 13;
    seed ^= seed >> 17;
    seed ^= seed << 5;
    return seed;
  endfunction

  // compare and count, unknown never matches
  task automatic chk(input string what, input logic [31:0] seen, input logic [31:0] exp);
    total_checks++;
    if (seen !== exp) begin
      error_cnt++;
      $display("CHECK FAILED %s expected %h seen %h", what, exp, seen);
    end
  endtask

  // prints counts and verdict, ends the run
  task automatic summarize();
    $display("checks %0d mismatches %0d", total_checks, error_cnt);
    if (error_cnt == 0 && total_checks > 0) $display("Result: passed");
    else $display("Result: failed");
    $finish;
  endtask

  // one apb transfer, request held until pready is sampled high
  task automatic apb(input logic wr, input logic [7:0] a, input logic [31:0] d,
                     output logic [31:0] r, output logic e);
    int n;
    @(posedge MCLK);
    PSEL <= 1'b1;
    PENABLE <= 1'b0;
    PWRITE <= wr;
    PADDR <= a;
    PWDATA <= d;
    @(posedge MCLK);
    PENABLE <= 1'b1;
    n = 0;
    do begin
      @(posedge MCLK);
      n++;
    end while (PREADY !== 1'b1 && n < 20);
    r = PRDATA;
    e = PSLVERR;
    PSEL <= 1'b0;
    PENABLE <= 1'b0;
    if (n >= 20) chk("pready", 32'h0, 32'h1);
  endtask

  // write with random upper half, which must be ignored
  task automatic wr(input logic [7:0] a, input logic [15:0] d);
    logic [31:0] r, u;
    logic e;
    u = xs();
    apb(1'b1, a, {u[31:16], d}, r, e);
  endtask

  // read and compare the word and the error flag
  task automatic rd(input logic [7:0] a, input logic [31:0] exp, input string what);
    logic [31:0] r;
    logic e;
    apb(1'b0, a, 32'h0, r, e);
    chk(what, r, exp);
    chk("rd_err", e, 32'h0);
  endtask

  // control outputs against an active set and the enables
  task automatic outs(input logic [15:0] c, input logic [15:0] t, input logic [1:0] e);
    chk("agd", GROUP_DELAY_COMP_ON, c[VFP_AGD_BIT]);
    chk("afr", ATTEN_COMP_ON, c[VFP_AFR_BIT]);
    chk("ano", NOISE_COMP_ON, c[VFP_ANO_BIT]);
    chk("full", FULL_CHANNEL_ON, c[VFP_FULL_BIT]);
    chk("mux", DELAY_MEASURE_SELECT, t[VFP_MUX_BIT]);
    chk("ext", USE_EXT_START_LEVEL, e[0]);
    chk("stl", SLICER_TWO_START_LEVEL, e[0] ? t[14:8] : VFP_INT_STL_DEF);
    chk("thr_ok", DELAY_THR_VALID, e[1]);
    chk("neg", NEG_DELAY_THRESHOLD, e[1] ? t[5:3] : 3'h0);
    chk("pos", POS_DELAY_THRESHOLD, e[1] ? t[2:0] : 3'h0);
  endtask

  // one field: vsync held well past the load, loads counted
  task automatic field(input logic ok1, input logic ok2, input logic src, input int exp);
    int cnt;
    @(posedge MCLK);
    SYNC_OK_ONE <= ok1;
    SYNC_OK_TWO <= ok2;
    repeat (3) @(posedge MCLK);
    if (src) VSYNC_TWO <= 1'b1;
    else VSYNC_ONE <= 1'b1;
    cnt = 0;
    repeat (16) begin
      @(posedge MCLK);
      if (FIELD_STROBE === 1'b1) cnt++;
    end
    VSYNC_ONE <= 1'b0;
    VSYNC_TWO <= 1'b0;
    repeat (6) @(posedge MCLK);
    chk("loads", cnt, exp);
  endtask

  // sixteen bits first-bit-first, then both framing hits
  task automatic shift16(input logic [15:0] v);
    for (int i = 15; i >= 0; i--) begin
      @(posedge MCLK);
      RX_BIT <= v[i];
      RX_BIT_VALID <= 1'b1;
    end
    @(posedge MCLK);
    RX_BIT_VALID <= 1'b0;
    RX_BIT <= ~v[0];
    repeat (3) @(posedge MCLK);
    chk("fc3_hit", FC3_HIT, ((v ^ a_fc3) & a_msk) == 16'h0000);
    chk("fc1_hit", FC1_HIT, v[7:0] == a_ctrl[15:8]);
  endtask

  // watchdog, far beyond the expected run
  initial begin
    repeat (60000) @(posedge MCLK);
    error_cnt++;
    summarize();
  end

  // main sequence
  initial begin
    logic [31:0] r, u;
    logic e;
    logic [3:0] hv[4];
    logic [3:0] ok_tab[4];
    seed = 32'h0000C5B3;
    error_cnt = 0;
    total_checks = 0;
    {PSEL, PENABLE, PWRITE, RX_BIT, RX_BIT_VALID, VSYNC_ONE, VSYNC_TWO} = 7'h00;
    {PADDR, PWDATA, SLICER_STATUS, WSS_EDGE_HITS} = '0;
    {SYNC_OK_ONE, SYNC_OK_TWO} = 2'h0;
    {a_fc3, a_msk, a_ctrl, a_thr, a_st, en, fields} = '0;
    // sync ok one, ok two, source, loads expected
    ok_tab = '{4'h9, 4'h7, 4'hE, 4'h0};
    RST = 1'b1;
    repeat (20) @(posedge MCLK);
    RST <= 1'b0;
    @(posedge MCLK);
    outs(16'h0000, 16'h0000, 2'h0);
    rd(VFP_OFS_CTRL, 32'h0, "ctrl_rst");
    // bad addresses refused, read-only words kept
    apb(1'b1, 8'h1C, 32'hFFFFFFFF, r, e);
    chk("slverr_hi", e, 32'h1);
    apb(1'b0, 8'h02, 32'h0, r, e);
    chk("slverr_al", e, 32'h1);
    chk("slverr_rd", r, 32'h0);
    wr(VFP_OFS_STATUS, 16'hFFFF);
    rd(VFP_OFS_STATUS, 32'h0, "ro_status");
    $display("test register_access done");
    for (int it = 0; it < 6; it++) begin
      u = xs();
      {msk, fc3} = u;
      if (it == 0) msk = 16'hFFFF;
      u = xs();
      ctrl = u[15:0];
      u = xs();
      thr = u[15:0] & 16'h7F7F;
      en = u[17:16];
      st = u[31:16];
      if (it == 0) ctrl[15:8] = fc3[7:0];
      if (it == 1) ctrl[4:1] = 4'hC;
      if (it == 4) ctrl[4:1] = 4'h0;
      wr(VFP_OFS_FC3, fc3);
      wr(VFP_OFS_FC3_MASK, msk);
      wr(VFP_OFS_CTRL, ctrl);
      wr(VFP_OFS_THR, thr);
      wr(VFP_OFS_ENABLE, {14'h0, en});
      rd(VFP_OFS_FC3, {16'h0, fc3}, "fc3_rd");
      rd(VFP_OFS_FC3_MASK, {16'h0, msk}, "mask_rd");
      rd(VFP_OFS_CTRL, {16'h0, ctrl}, "ctrl_rd");
      rd(VFP_OFS_THR, {16'h0, thr}, "thr_rd");
      rd(VFP_OFS_ENABLE, {30'h0, en}, "en_rd");
      outs(a_ctrl, a_thr, en);
      SLICER_STATUS <= st;
      field(ok_tab[it % 4][3], ok_tab[it % 4][2], ok_tab[it % 4][1], ok_tab[it % 4][0]);
      if (ok_tab[it % 4][0]) begin
        {a_fc3, a_msk, a_ctrl, a_thr, a_st} = {fc3, msk, ctrl, thr, st};
        fields++;
      end
      outs(a_ctrl, a_thr, en);
      rd(VFP_OFS_FIELDS, {16'h0, fields}, "fields");
      SLICER_STATUS <= ~st;
      rd(VFP_OFS_STATUS, {16'h0, a_st}, "snapshot");
      shift16(a_fc3);
      u = xs();
      shift16(a_fc3 ^ (16'h0001 << u[3:0]));
      hv = '{a_ctrl[4:1], a_ctrl[4:1] - 4'h1, 4'hF, 4'h0};
      foreach (hv[k]) begin
        @(posedge MCLK);
        WSS_EDGE_HITS <= hv[k];
        repeat (3) @(posedge MCLK);
        chk("wss_hit", WSS_FC_HIT, hv[k] >= a_ctrl[4:1]);
      end
      $display("test field %0d done", it);
    end
    summarize();
  end
endmodule // vbi_slicer_field_params_tb_top
